// ---- imw_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Master always sends write bit zero
// - Acknowledge address and every data byte
// - Several command bytes per transfer, in order
// - Byte splits: op top three, value five
// - Op 001 margining, 011 timer
// - Guard byte: op with zero value first
// - Execute only the op armed by guard
// - Margin bit 4 picks linear or switcher
// - Codes map to nominal, +1..+7, -1..-7 percent
// - Both supplies: one guard, two commands
// - Timer value: off, four periods, window bit
// - Valid period command starts the timer
// - Refresh in open window restarts, reapplies
// - Address 11101 plus two strap bits
// - Stop returns to idle, await start
// ============================================================
// Command-interpreting two-wire slave
module imw_dev #(
  parameter int unsigned P0_CYC = imw_pkg::T0_MS * imw_pkg::CLK_KHZ,
  parameter int unsigned P1_CYC = imw_pkg::T1_MS * imw_pkg::CLK_KHZ,
  parameter int unsigned P2_CYC = imw_pkg::T2_MS * imw_pkg::CLK_KHZ,
  parameter int unsigned P3_CYC = imw_pkg::T3_MS * imw_pkg::CLK_KHZ
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Link
  imw_i2c_if.slave         bus,
  // Address straps
  input  wire logic        clock_select_strap,
  input  wire logic        addr_strap,
  // Margin settings in signed percent
  output logic signed [3:0] linear_regulator_output_pct,
  output logic signed [3:0] switcher_pct,
  // Supervision timer state
  output logic             supervision_timer_on,
  output logic       [1:0] supervision_timer_period,
  output logic             supervision_timer_window,
  output logic             supervision_timer_window_open,
  output logic             supervision_timer_expired
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_ACK  = 3'b010,
    S_DATA = 3'b011,
    S_IGN  = 3'b100
  } imw_st_e;

  // Margin code to signed percent
  function automatic logic signed [3:0] pct(input logic [3:0] c);
    pct = c[3] ? 4'(-4'sd1 - signed'({1'b0, c[2:0]})) : {1'b0, c[2:0]};
  endfunction

  // Period select to cycle count
  function automatic logic [31:0] per(input logic [1:0] s);
    unique case (s)
      2'h0:    per = 32'(P0_CYC);
      2'h1:    per = 32'(P1_CYC);
      2'h2:    per = 32'(P2_CYC);
      default: per = 32'(P3_CYC);
    endcase
  endfunction

  logic [2:0] scl_p, sda_p;
  logic [1:0] strap_m, strap_s;
  logic       scl_rise, scl_fall, start_c, stop_c;
  imw_st_e    st, next_st;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sh, next_sh;
  logic       ack, next_ack;
  logic       byte_done;
  imw_pkg::imw_arm_e arm, next_arm;
  logic signed [3:0] lin, next_lin, sw, next_sw;
  logic       ton, next_ton, twin, next_twin, wopen, next_wopen;
  logic       texp, next_texp;
  logic [1:0] tsel, next_tsel;
  logic [31:0] tcnt, next_tcnt;
  logic [2:0] op;
  logic [4:0] val;

  // ============================================================
  // Synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      scl_p   <= 3'h7;
      sda_p   <= 3'h7;
      strap_m <= 2'h0;
      strap_s <= 2'h0;
    end else begin
      scl_p   <= {scl_p[1:0], bus.scl};
      sda_p   <= {sda_p[1:0], bus.sda};
      strap_m <= {clock_select_strap, addr_strap};
      strap_s <= strap_m;
    end
  end
  assign scl_rise = scl_p[1] && !scl_p[2];
  assign scl_fall = !scl_p[1] && scl_p[2];
  assign start_c  = scl_p[1] && scl_p[2] && !sda_p[1] && sda_p[2];
  assign stop_c   = scl_p[1] && scl_p[2] && sda_p[1] && !sda_p[2];
  assign byte_done = scl_fall && cnt == 4'h8 && st == S_DATA;

  // ============================================================
  // Bit and byte framing
  always_comb begin
    next_st  = st;
    next_cnt = cnt;
    next_sh  = sh;
    next_ack = ack;
    if (start_c) begin
      next_st  = S_ADDR;
      next_cnt = 4'h0;
      next_ack = 1'h0;
    end else if (stop_c) begin
      next_st  = S_IDLE;
      next_ack = 1'h0;
    end else if (scl_rise && cnt != 4'h8
                 && (st == S_ADDR || st == S_DATA)) begin
      next_sh  = {sh[6:0], sda_p[1]};
      next_cnt = cnt + 4'h1;
    end else if (scl_fall) begin
      unique case (st)
        S_ADDR: if (cnt == 4'h8) begin
          if (sh == {imw_pkg::ADDR_HI, strap_s, imw_pkg::RW_WR}) begin
            next_st  = S_ACK;
            next_ack = 1'h1;
          end else begin
            next_st = S_IGN;
          end
        end
        S_DATA: if (cnt == 4'h8) begin
          next_st  = S_ACK;
          next_ack = 1'h1;
        end
        S_ACK: begin
          // Release after the ninth clock; next byte follows
          next_st  = S_DATA;
          next_ack = 1'h0;
          next_cnt = 4'h0;
        end
        default: next_st = st;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st  <= S_IDLE;
      cnt <= 4'h0;
      sh  <= 8'h00;
      ack <= 1'h0;
    end else begin
      st  <= next_st;
      cnt <= next_cnt;
      sh  <= next_sh;
      ack <= next_ack;
    end
  end

  // ============================================================
  // Command interpreter and supervision timer
  // split fields
  assign op  = sh[7:5];
  assign val = sh[4:0];

  always_comb begin
    next_arm   = arm;
    next_lin   = lin;
    next_sw    = sw;
    next_ton   = ton;
    next_twin  = twin;
    next_tsel  = tsel;
    next_texp  = 1'h0;
    next_tcnt  = tcnt;
    // Timer runs; expiry pulses and reloads
    if (ton) begin
      next_tcnt = tcnt + 32'h1;
      if (tcnt >= per(tsel) - 32'h1) begin
        next_tcnt = 32'h0;
        next_texp = 1'h1;
      end
    end
    if (start_c || stop_c) begin
      next_arm = imw_pkg::A_NONE;
    end else if (byte_done) begin
      if (arm == imw_pkg::A_MARG && op == imw_pkg::OP_MARGIN) begin
        if (val[3:0] != imw_pkg::MARG_BAD) begin
          if (val[4]) next_sw = pct(val[3:0]);
          else next_lin = pct(val[3:0]);
        end
      end else if (arm == imw_pkg::A_TMR && op == imw_pkg::OP_TIMER) begin
        if (val == imw_pkg::VAL_GUARD) begin
          next_ton  = 1'h0;
          next_tcnt = 32'h0;
        // early refresh in window mode is refused
        end else if (val[4:3] == 2'h1 && (!ton || wopen)) begin
          next_ton  = 1'h1;
          next_twin = val[2];
          next_tsel = val[1:0];
          next_tcnt = 32'h0;
          next_texp = 1'h0;
        end
      end else if (val == imw_pkg::VAL_GUARD && op == imw_pkg::OP_MARGIN) begin
        next_arm = imw_pkg::A_MARG;
      end else if (val == imw_pkg::VAL_GUARD && op == imw_pkg::OP_TIMER) begin
        next_arm = imw_pkg::A_TMR;
      end else begin
        next_arm = imw_pkg::A_NONE;
      end
    end
    // Window opens in the second half of the period
    next_wopen = !next_twin || next_tcnt >= (per(next_tsel) >> 1);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      arm   <= imw_pkg::A_NONE;
      lin   <= 4'sh0;
      sw    <= 4'sh0;
      ton   <= 1'h0;
      twin  <= 1'h0;
      tsel  <= 2'h0;
      tcnt  <= 32'h0;
      texp  <= 1'h0;
      wopen <= 1'h1;
    end else begin
      arm   <= next_arm;
      lin   <= next_lin;
      sw    <= next_sw;
      ton   <= next_ton;
      twin  <= next_twin;
      tsel  <= next_tsel;
      tcnt  <= next_tcnt;
      texp  <= next_texp;
      wopen <= next_wopen;
    end
  end

  // ============================================================
  // Outputs
  assign bus.sda_s_o  = 1'h0;
  assign bus.sda_s_oe = ack;
  assign linear_regulator_output_pct   = lin;
  assign switcher_pct                  = sw;
  assign supervision_timer_on          = ton;
  assign supervision_timer_period      = tsel;
  assign supervision_timer_window      = twin;
  assign supervision_timer_window_open = wopen;
  assign supervision_timer_expired     = texp;
endmodule // imw_dev
`default_nettype wire

// ---- imw_pkg.sv ----
`default_nettype none
// ============================================================
// Shared constants for the command link
package imw_pkg;
  // Clock and serial rate
  localparam int unsigned CLK_KHZ = 200000;
  localparam int unsigned SCL_KHZ = 400;
  localparam int unsigned Q_CYC   = CLK_KHZ / (4 * SCL_KHZ);
  // Supervision timer periods in ms
  localparam int unsigned T0_MS = 1280;
  localparam int unsigned T1_MS = 320;
  localparam int unsigned T2_MS = 80;
  localparam int unsigned T3_MS = 20;
  // Slave address fixed upper bits
  localparam logic [4:0] ADDR_HI = 5'h1D;
  localparam logic       RW_WR   = 1'h0;
  // Operation fields
  localparam logic [2:0] OP_MARGIN = 3'h1;
  localparam logic [2:0] OP_TIMER  = 3'h3;
  localparam logic [4:0] VAL_GUARD = 5'h00;
  localparam logic [3:0] MARG_BAD  = 4'hF;
  // Host register offsets
  localparam logic [7:0] REG_ADDR = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam int unsigned CTRL_GO = 8;
  // Guard arming states
  typedef enum logic [1:0] {
    A_NONE = 2'b00,
    A_MARG = 2'b01,
    A_TMR  = 2'b10
  } imw_arm_e;
endpackage
`default_nettype wire

// ---- imw_i2c_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Open-drain two-wire link, levels resolved from the enables
interface imw_i2c_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Pull-up wins unless some end drives low
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport master (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe,
                  input scl, sda);
  modport slave (output sda_s_o, sda_s_oe, input scl, sda);
endinterface
`default_nettype wire

// ---- imw_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Write-only master: sends address then up to three bytes
module imw_host (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Link
  imw_i2c_if.master        bus,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BIT   = 2'b10,
    H_STOP  = 2'b11
  } imw_hst_e;

  imw_hst_e    st, next_st;
  logic [1:0]  ph, next_ph;
  logic [3:0]  bitn, next_bitn;
  logic [1:0]  byten, next_byten;
  logic [1:0]  nbytes, next_nbytes;
  logic        nack, next_nack;
  logic        scl_lo, next_scl_lo;
  logic        sda_lo, next_sda_lo;
  logic [6:0]  addr7, next_addr7;
  logic [23:0] data24, next_data24;
  logic [31:0] rdata, next_rdata;
  logic [9:0]  qdiv;
  logic        tick;
  logic        sda_m1, sda_s;
  logic [7:0]  cur;

  // ============================================================
  // Quarter-bit enable and link input synchroniser
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      qdiv   <= 10'h000;
      sda_m1 <= 1'h1;
      sda_s  <= 1'h1;
    end else begin
      qdiv   <= tick ? 10'h000 : qdiv + 10'h001;
      sda_m1 <= bus.sda;
      sda_s  <= sda_m1;
    end
  end
  assign tick = (qdiv == 10'(imw_pkg::Q_CYC - 1));

  // ============================================================
  // Frame sequencer and register port
  always_comb begin
    next_st     = st;
    next_ph     = ph;
    next_bitn   = bitn;
    next_byten  = byten;
    next_nbytes = nbytes;
    next_nack   = nack;
    next_scl_lo = scl_lo;
    next_sda_lo = sda_lo;
    next_addr7  = addr7;
    next_data24 = data24;
    next_rdata  = 32'h0000_0000;
    unique case (byten)
      2'h0:    cur = {addr7, imw_pkg::RW_WR};
      2'h1:    cur = data24[7:0];
      2'h2:    cur = data24[15:8];
      default: cur = data24[23:16];
    endcase
    if (reg_rd) begin
      unique case (reg_addr)
        imw_pkg::REG_ADDR: next_rdata = {25'h0, addr7};
        imw_pkg::REG_DATA: next_rdata = {8'h00, data24};
        imw_pkg::REG_STAT: next_rdata = {30'h0, nack, st != H_IDLE};
        default:           next_rdata = 32'h0000_0000;
      endcase
    end
    // Writes while busy are dropped so a frame never changes midway
    if (reg_wr && st == H_IDLE) begin
      if (reg_addr == imw_pkg::REG_ADDR) next_addr7 = reg_wdata[6:0];
      if (reg_addr == imw_pkg::REG_DATA) next_data24 = reg_wdata[23:0];
      if (reg_addr == imw_pkg::REG_CTRL && reg_wdata[imw_pkg::CTRL_GO]
          && reg_wdata[1:0] != 2'h0) begin
        next_nbytes = reg_wdata[1:0];
        next_st     = H_START;
        next_ph     = 2'h0;
        next_nack   = 1'h0;
        next_byten  = 2'h0;
        next_bitn   = 4'h0;
      end
    end
    if (tick && st != H_IDLE) begin
      next_ph = ph + 2'h1;
      unique case (st)
        H_START: begin
          if (ph == 2'h1) next_sda_lo = 1'h1;
          if (ph == 2'h2) next_scl_lo = 1'h1;
          if (ph == 2'h3) next_st = H_BIT;
        end
        H_BIT: begin
          if (ph == 2'h0) begin
            next_scl_lo = 1'h1;
            next_sda_lo = (bitn < 4'h8) ? !cur[3'(4'h7 - bitn)] : 1'h0;
          end
          if (ph == 2'h1) next_scl_lo = 1'h0;
          if (ph == 2'h2 && bitn == 4'h8 && sda_s) next_nack = 1'h1;
          if (ph == 2'h3) begin
            next_scl_lo = 1'h1;
            next_bitn   = bitn + 4'h1;
            if (bitn == 4'h8) begin
              next_bitn = 4'h0;
              if (nack || byten == nbytes) next_st = H_STOP;
              else next_byten = byten + 2'h1;
            end
          end
        end
        default: begin
          if (ph == 2'h0) next_sda_lo = 1'h1;
          if (ph == 2'h1) next_scl_lo = 1'h0;
          if (ph == 2'h2) next_sda_lo = 1'h0;
          if (ph == 2'h3) next_st = H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st     <= H_IDLE;
      ph     <= 2'h0;
      bitn   <= 4'h0;
      byten  <= 2'h0;
      nbytes <= 2'h0;
      nack   <= 1'h0;
      scl_lo <= 1'h0;
      sda_lo <= 1'h0;
      addr7  <= 7'h00;
      data24 <= 24'h000000;
      rdata  <= 32'h0000_0000;
    end else begin
      st     <= next_st;
      ph     <= next_ph;
      bitn   <= next_bitn;
      byten  <= next_byten;
      nbytes <= next_nbytes;
      nack   <= next_nack;
      scl_lo <= next_scl_lo;
      sda_lo <= next_sda_lo;
      addr7  <= next_addr7;
      data24 <= next_data24;
      rdata  <= next_rdata;
    end
  end

  // Open drain: only ever pull low
  assign bus.scl_m_o  = 1'h0;
  assign bus.sda_m_o  = 1'h0;
  assign bus.scl_m_oe = scl_lo;
  assign bus.sda_m_oe = sda_lo;
  assign reg_rdata    = rdata;
endmodule // imw_host
`default_nettype wire

// ---- imw_i2c_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Link checker: acknowledge placement and framing
module imw_i2c_chk (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Resolved wires and the device pull-low enable
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic sda_s_oe
);
  // Bound on ack to ninth rise, well above one low phase
  localparam int ACK_MAX = 1000;
  logic       scl_d;
  logic       sda_d;
  logic [3:0] bit_cnt;
  logic [3:0] byte_n;
  logic [7:0] shreg;
  logic       acked;
  logic       start;
  logic       stop;
  logic       rise;
  logic       fall;
  // Conditions seen on the wire levels
  assign rise  = scl && !scl_d;
  assign fall  = !scl && scl_d;
  assign start = scl && scl_d && sda_d && !sda;
  assign stop  = scl && scl_d && !sda_d && sda;
  // Bit and byte position since the last start
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      scl_d   <= 1'b1;
      sda_d   <= 1'b1;
      bit_cnt <= 4'h0;
      byte_n  <= 4'h0;
      shreg   <= 8'h00;
      acked   <= 1'b0;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      if (start) begin
        bit_cnt <= 4'h0;
        byte_n  <= 4'h0;
        acked   <= 1'b0;
      end else begin
        if (rise) begin
          bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
          shreg   <= {shreg[6:0], sda};
        end
        if (rise && bit_cnt == 4'h8) byte_n <= byte_n + 4'h1;
        if (sda_s_oe && byte_n == 4'h0) acked <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_ack_place;
    $rose(sda_s_oe) |-> !scl && bit_cnt == 4'h8;
  endproperty
  a_ack_place: assert property (p_ack_place)
    else $error("ack raised outside the ninth low phase");
  property p_ack_hold;
    $rose(sda_s_oe) |-> sda_s_oe throughout (##[1:ACK_MAX] rise);
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("ack dropped before the ninth clock high");
  property p_ack_drop;
    $fell(sda_s_oe) |-> !scl;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("ack released while the clock is high");
  property p_rw_zero;
    $rose(sda_s_oe) && byte_n == 4'h0 |-> !shreg[0];
  endproperty
  a_rw_zero: assert property (p_rw_zero)
    else $error("address acked with the read bit set");
  property p_data_ack;
    fall && bit_cnt == 4'h8 && byte_n != 4'h0 && acked |-> ##[1:8] sda_s_oe;
  endproperty
  a_data_ack: assert property (p_data_ack)
    else $error("data byte not acked");
  property p_stop_idle;
    stop |-> !sda_s_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("data line held at stop");
  property p_start_idle;
    start |=> !sda_s_oe [*8];
  endproperty
  a_start_idle: assert property (p_start_idle)
    else $error("data line pulled after start");
  property p_stop_whole;
    stop |-> bit_cnt == 4'h1;
  endproperty
  a_stop_whole: assert property (p_stop_whole)
    else $error("stop in the middle of a byte");
  // Main scenarios reached
  c_addr_ack: cover property ($rose(sda_s_oe) && byte_n == 4'h0);
  c_third_ack: cover property ($rose(sda_s_oe) && byte_n == 4'h3);
  c_stop: cover property (stop);
endmodule // imw_i2c_chk
`default_nettype wire

// ---- i2c_margin_watchdog_cmd_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host and device facing each other on one link
module i2c_margin_watchdog_cmd_tb_top;
  localparam int unsigned P3 = 50;
  logic              core_clk;
  logic              nrst;
  logic        [7:0] reg_addr;
  logic       [31:0] reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic       [31:0] reg_rdata;
  logic              strap_a1;
  logic              strap_a0;
  logic signed [3:0] lin_pct;
  logic signed [3:0] sw_pct;
  logic              t_on;
  logic        [1:0] t_per;
  logic              t_win;
  logic              t_open;
  logic              t_exp;
  logic       [31:0] rv;
  logic        [7:0] rbyte;
  int                n_mismatch;
  int                n_compared;
  int                seed;
  int                i;
  int                m_arm, m_lin, m_sw, m_on, m_per, m_win;
  imw_i2c_if bus ();
  imw_host i_imw_host (.core_clk(core_clk), .nrst(nrst), .bus(bus),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // Short periods keep expiry inside the run
  imw_dev #(.P0_CYC(400), .P1_CYC(200), .P2_CYC(100), .P3_CYC(P3))
  i_imw_dev (.core_clk(core_clk), .nrst(nrst), .bus(bus),
    .clock_select_strap(strap_a1), .addr_strap(strap_a0),
    .linear_regulator_output_pct(lin_pct), .switcher_pct(sw_pct),
    .supervision_timer_on(t_on), .supervision_timer_period(t_per),
    .supervision_timer_window(t_win),
    .supervision_timer_window_open(t_open),
    .supervision_timer_expired(t_exp));
  imw_i2c_chk i_imw_i2c_chk (.core_clk(core_clk), .nrst(nrst),
    .scl(bus.scl), .sda(bus.sda), .sda_s_oe(bus.sda_s_oe));
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Comparison with count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Reference interpreter, one byte at a time
  task automatic model(input int b);
    int op;
    int v;
    int p;
    op = b >> 5;
    v  = b & 31;
    p  = ((v & 15) < 8) ? (v & 15) : 7 - (v & 15);
    if (v == 0 && m_arm != op && (op == 1 || op == 3)) m_arm = op;
    else if (m_arm == op && op == 1) begin
      if ((v & 15) != 15 && (v & 16) != 0) m_sw = p;
      else if ((v & 15) != 15) m_lin = p;
    end else if (m_arm == op && op == 3) begin
      if (v == 0) m_on = 0;
      else if ((v >> 3) == 1) begin
        m_on  = 1;
        m_per = v & 3;
        m_win = (v >> 2) & 1;
      end
    end else m_arm = 0;
  endtask
  // Settings against the reference
  task automatic cmp_out;
    chk("linear", {28'h0, 4'(m_lin)}, {28'h0, lin_pct});
    chk("switcher", {28'h0, 4'(m_sw)}, {28'h0, sw_pct});
    chk("timer_on", 32'(m_on), {31'h0, t_on});
    chk("period", 32'(m_per), {30'h0, t_per});
    chk("window", 32'(m_win), {31'h0, t_win});
  endtask
  // One transfer: address then n bytes, low byte first
  task automatic frame(input int n, input logic [23:0] d);
    wr(imw_pkg::REG_ADDR, {25'h0, imw_pkg::ADDR_HI, strap_a1, strap_a0});
    wr(imw_pkg::REG_DATA, {8'h00, d});
    wr(imw_pkg::REG_CTRL, 32'(n) | (32'h1 << imw_pkg::CTRL_GO));
    rd(imw_pkg::REG_STAT, rv);
    chk("busy", 32'h1, rv & 32'h1);
    for (int k = 0; k < 12000 && rv[0] !== 1'b0; k++)
      rd(imw_pkg::REG_STAT, rv);
    chk("status", 32'h0, rv);
    m_arm = 0;
    for (int k = 0; k < n; k++) model(int'((d >> (8 * k)) & 24'hFF));
    m_arm = 0;
    cmp_out;
    $display("TB: transfer of %0d bytes done", n);
  endtask
  // Verdict and end of run
  task automatic close_out;
    $display("TB: %0d compared, %0d mismatched", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Hang guard: five transfers take about 75k cycles
  initial begin
    repeat (90000) @(posedge core_clk);
    n_mismatch++;
    $display("ERROR watchdog expected done seen hang");
    close_out;
  end
  // Main sequence
  initial begin
    seed      = 37560;
    nrst      = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    strap_a1  = 1'($random(seed));
    strap_a0  = 1'($random(seed));
    {m_arm, m_lin, m_sw, m_on, m_per, m_win} = '0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    #1 cmp_out;
    chk("open_rst", 32'h1, {31'h0, t_open});
    rd(8'h10, rv);
    chk("unmapped", 32'h0, rv);
    $display("TB: reset state done");
    // unguarded byte ignored, then guard and random switcher code
    rbyte = 8'h30 | (8'($random(seed)) & 8'h0F);
    frame(3, {rbyte, 8'h20, 8'h25});
    // one guard, then linear +5 and switcher -5
    frame(3, {8'h3C, 8'h25, 8'h20});
    frame(2, {8'h00, 8'h6F, 8'h60});
    for (i = 0; i < 4 * P3 && t_exp !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk("expired", 32'h1, {31'h0, t_exp});
    // Window closed in the first half of a period, open in the second
    chk("window_shut", 32'h0, {31'h0, t_open});
    repeat (P3 / 2 + 5) @(posedge core_clk);
    #1;
    chk("window_open", 32'h1, {31'h0, t_open});
    $display("TB: timer expiry done");
    // foreign address: no ack, nothing changes
    wr(imw_pkg::REG_ADDR,
       {25'h0, imw_pkg::ADDR_HI, !strap_a1, strap_a0});
    wr(imw_pkg::REG_CTRL, 32'h0000_0101);
    rd(imw_pkg::REG_STAT, rv);
    for (i = 0; i < 12000 && rv[0] !== 1'b0; i++)
      rd(imw_pkg::REG_STAT, rv);
    chk("nack", 32'h2, rv);
    cmp_out;
    $display("TB: foreign address done");
    // timer guard sent twice turns the timer off
    frame(2, {8'h00, 8'h60, 8'h60});
    close_out;
  end
endmodule // i2c_margin_watchdog_cmd_tb_top
`default_nettype wire
